// [logic/dcb_pkg.sv]
// constants shared by the dc-link ballast controller and monitor
package dcb_pkg;

	// ---------------------------------------------------------------
	// clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ   = 50_000_000; // ref_clk rate
	localparam int TICK_US  = 1000;       // model step, 1 ms
	localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
	localparam int SURGE_MS = 1000;       // short surge, 1 second
	localparam logic [10:0] SURGE_TICKS = 11'(SURGE_MS * 1000 / TICK_US);

	// ---------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ---------------------------------------------------------------
	localparam logic [3:0] IDX_CTRL  = 4'h1; // ballast_control_flags
	localparam logic [3:0] IDX_THR   = 4'h2; // ballast_voltage_threshold
	localparam logic [3:0] IDX_HYST  = 4'h3; // ballast_hysteresis
	localparam logic [3:0] IDX_RES   = 4'h4; // resistor_nominal_value
	localparam logic [3:0] IDX_LTCAP = 4'h5; // long_term_energy_cap
	localparam logic [3:0] IDX_LTWIN = 4'h6; // long_term_window_time
	localparam logic [3:0] IDX_STCAP = 4'h7; // short_term_energy_cap
	localparam logic [3:0] IDX_COOL  = 4'h8; // resistor_cooling_rate
	localparam logic [3:0] IDX_OVV   = 4'h9; // overvoltage threshold
	localparam logic [3:0] IDX_STAT  = 4'hA; // status, write one to clear
	localparam logic [3:0] IDX_CODE  = 4'hB; // last error code

	// ---------------------------------------------------------------
	// fields and reset values
	// ---------------------------------------------------------------
	localparam int CTRL_EN  = 0;  // ballast enable
	localparam int CTRL_INV = 1;  // inverted pin polarity
	localparam int ST_INH   = 0;  // ballast inhibited (live)
	localparam int ST_PERR  = 1;  // parameters invalid (live)
	localparam int ST_OVV   = 2;  // overvoltage, sticky
	localparam int ST_WARN  = 3;  // energy warning, sticky
	localparam int ST_ON    = 4;  // hysteresis comparator on (live)
	localparam logic [31:0] RST_REG = 32'h0000_0000;
	localparam logic [31:0] RST_OVV = 32'hFFFF_FFFF;

	// ---------------------------------------------------------------
	// error codes and units
	// ---------------------------------------------------------------
	localparam logic [15:0] ERR_PARAM  = 16'h7110;
	localparam logic [15:0] ERR_ENERGY = 16'h7113;
	localparam logic [15:0] ERR_OVV    = 16'h0001; // arbitrary value
	localparam logic [47:0] UWS_PER_MWS = 48'h0000_0000_03E8;

endpackage : dcb_pkg

// [logic/dcb_tick.sv]
// millisecond step enable for the thermal model
`timescale 1ns/100ps
module dcb_tick #(
	parameter int CYC = 50000
) (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic srst,
	// step enable
	output wire logic tick
);
	typedef struct packed {
		logic [31:0] cnt;  // cycles in the current step
		logic        tick; // one-cycle pulse
	} dcb_tick_s;

	dcb_tick_s s_q;
	dcb_tick_s s_d;

	// count up through the step and pulse at its end
	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (s_q.cnt >= 32'(CYC - 1)) begin
			s_d.cnt = 32'h0000_0000;
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + 32'h0000_0001;
		end
	end

	// state register
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.tick;
endmodule : dcb_tick

// [logic/dcb_div.sv]
// serial restoring divider, one quotient bit per cycle
`timescale 1ns/100ps
module dcb_div #(
	parameter int W = 32
) (
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         srst,
	// request
	input  wire logic         start,
	input  wire logic [W-1:0] num,
	input  wire logic [W-1:0] den,
	// answer
	output wire logic [W-1:0] quo,
	output wire logic         done
);
	localparam int CW = $clog2(W + 1);

	typedef struct packed {
		logic [W-1:0]  rem;  // partial remainder
		logic [W-1:0]  quo;  // quotient being shifted in
		logic [W-1:0]  num;  // dividend, shifted out msb first
		logic [W-1:0]  den;  // divisor
		logic [CW-1:0] cnt;  // bits still to do
		logic          busy; // division in progress
		logic          done; // one-cycle pulse
	} dcb_div_s;

	dcb_div_s s_q;
	dcb_div_s s_d;

	// a zero divisor yields all ones, which is harmless here
	always_comb begin
		logic [W:0] t;
		t = {s_q.rem, s_q.num[W-1]};
		s_d = s_q;
		s_d.done = 1'b0;
		if (start) begin
			s_d.num = num;
			s_d.den = den;
			s_d.rem = '0;
			s_d.cnt = CW'(W);
			s_d.busy = 1'b1;
		end else if (s_q.busy) begin
			s_d.num = s_q.num << 1;
			if (t >= {1'b0, s_q.den}) begin
				s_d.rem = W'(t - {1'b0, s_q.den});
				s_d.quo = {s_q.quo[W-2:0], 1'b1};
			end else begin
				s_d.rem = t[W-1:0];
				s_d.quo = {s_q.quo[W-2:0], 1'b0};
			end
			s_d.cnt = s_q.cnt - CW'(1);
			if (s_q.cnt == CW'(1)) begin
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign quo  = s_q.quo;
	assign done = s_q.done;
endmodule : dcb_div

// [logic/dcb_ballast.sv]
// dc-link ballast controller and resistor energy monitor, apb slave
// ---------------------------------------------------------------
// How it works
// - ballast switches only while enable bit set
// - pin active high, bit 1 inverts it
// - threshold and hysteresis from subindices 02, 03
// - overvoltage despite ballast: error, output stage off
// - accumulate resistor energy, subtract convection losses
// - energy over limit: inhibit ballast, warn 7113
// - inhibit lifts itself once resistor has cooled
// - cooling power drains stored energy each step
// - surge under one second checked against short cap
// - energy within reference window checked against long cap
// - invalid resistor parameters raise error 7110
// - resistor parameters from subindices 04 to 08
// ---------------------------------------------------------------
//
// The APB register port was left to the implementer.
`timescale 1ns/100ps
module dcb_ballast
	import dcb_pkg::*;
#(
	parameter int TICK_CYC_P = TICK_CYC // cycles per 1 ms model step
) (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        srst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output wire logic [31:0] prdata,
	output wire logic        pready,
	output wire logic        pslverr,
	// measured dc-link voltage in mV, from on-chip logic
	input  wire logic [15:0] dc_link_mv,
	// ballast and power stage
	output wire logic        ballast_pin,
	output wire logic        stage_off,
	// error reporting
	output wire logic [15:0] err_code,
	output wire logic        err_strobe
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [31:0] ctrl, thr, hyst, res;  // control and resistor regs
		logic [31:0] ltcap, ltwin, stcap;   // energy caps, window
		logic [31:0] cool, ovv;             // cooling mW, overvoltage mV
		logic [47:0] e_st, e_win, e_th;     // energies in uWs
		logic [31:0] pwr;                   // resistor power in mW
		logic [31:0] sq;                    // voltage squared
		logic [31:0] win_ms;                // position in window
		logic [10:0] surge;                 // age of current surge
		logic        go, on, inh, perr, ovv_err, warn;
		logic        pin, err_pulse, ready, slverr;
		logic [15:0] code;
		logic [31:0] rdata;
	} dcb_state_s;

	dcb_state_s s_q;
	dcb_state_s s_d;
	logic        tick;     // 1 ms step
	logic [31:0] quo;      // divider result
	logic        div_done; // divider finished
	logic [31:0] low;      // switch-off level
	logic        act;      // ballast really conducting
	logic        perr_now; // parameters bad right now
	logic        over;     // some energy limit exceeded
	logic        rel;      // cooled enough to release
	logic [47:0] add;      // energy of this step

	// byte address of a register index
	function automatic logic [31:0] reg_addr(input logic [3:0] idx);
		return {26'h0, idx, 2'b00};
	endfunction : reg_addr

	// energy cap in uWs from mWs
	function automatic logic [47:0] uws(input logic [31:0] mws);
		return 48'({16'h0, mws} * UWS_PER_MWS);
	endfunction : uws

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	dcb_tick #(.CYC(TICK_CYC_P)) u_tick (
		.ref_clk (ref_clk),
		.srst    (srst),
		.tick    (tick)
	);

	// power = mV^2 / mOhm gives mW; serial, finishes well inside 1 ms
	dcb_div #(.W(32)) u_div (
		.ref_clk (ref_clk),
		.srst    (srst),
		.start   (s_q.go),
		.num     (s_q.sq),
		.den     (s_q.res),
		.quo     (quo),
		.done    (div_done)
	);

	// ---------------------------------------------------------------
	// combinational terms
	// ---------------------------------------------------------------
	always_comb begin
		low = (s_q.thr > s_q.hyst) ? s_q.thr - s_q.hyst : 32'h0;
		act = s_q.on && s_q.ctrl[CTRL_EN] && !s_q.inh && !s_q.perr;
		// unrealistic sets, including a short cap above the long one
		perr_now = (s_q.res == 32'h0) || (s_q.ltwin == 32'h0) ||
			(s_q.stcap == 32'h0) || (s_q.ltcap < s_q.stcap) ||
			(s_q.cool == 32'h0);
		over = (s_q.e_st > uws(s_q.stcap)) ||
			(s_q.e_win > uws(s_q.ltcap)) ||
			(s_q.e_th > uws(s_q.ltcap));
		rel = !over && (s_q.e_th < (uws(s_q.ltcap) >> 1));
		add = act ? {16'h0, s_q.pwr} : 48'h0;
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.err_pulse = 1'b0;
		s_d.ready = 1'b0;
		s_d.slverr = 1'b0;
		s_d.go = 1'b0;
		// apb: one wait state, answer in second access cycle
		if (psel && penable && !s_q.ready) begin
			s_d.ready = 1'b1;
			s_d.rdata = 32'h0;
			if (paddr == reg_addr(IDX_CTRL)) begin
				s_d.rdata = s_q.ctrl;
				if (pwrite) s_d.ctrl = pwdata;
			end else if (paddr == reg_addr(IDX_THR)) begin
				s_d.rdata = s_q.thr;
				if (pwrite) s_d.thr = pwdata;
			end else if (paddr == reg_addr(IDX_HYST)) begin
				s_d.rdata = s_q.hyst;
				if (pwrite) s_d.hyst = pwdata;
			end else if (paddr == reg_addr(IDX_RES)) begin
				s_d.rdata = s_q.res;
				if (pwrite) s_d.res = pwdata;
			end else if (paddr == reg_addr(IDX_LTCAP)) begin
				s_d.rdata = s_q.ltcap;
				if (pwrite) s_d.ltcap = pwdata;
			end else if (paddr == reg_addr(IDX_LTWIN)) begin
				s_d.rdata = s_q.ltwin;
				if (pwrite) s_d.ltwin = pwdata;
			end else if (paddr == reg_addr(IDX_STCAP)) begin
				s_d.rdata = s_q.stcap;
				if (pwrite) s_d.stcap = pwdata;
			end else if (paddr == reg_addr(IDX_COOL)) begin
				s_d.rdata = s_q.cool;
				if (pwrite) s_d.cool = pwdata;
			end else if (paddr == reg_addr(IDX_OVV)) begin
				s_d.rdata = s_q.ovv;
				if (pwrite) s_d.ovv = pwdata;
			end else if (paddr == reg_addr(IDX_STAT)) begin
				s_d.rdata = {27'h0, s_q.on, s_q.warn, s_q.ovv_err,
					s_q.perr, s_q.inh};
				// sticky flags clear here; sets below win
				if (pwrite && pwdata[ST_OVV]) s_d.ovv_err = 1'b0;
				if (pwrite && pwdata[ST_WARN]) s_d.warn = 1'b0;
			end else if (paddr == reg_addr(IDX_CODE)) begin
				s_d.rdata = {16'h0, s_q.code};
			end else begin
				s_d.slverr = 1'b1; // unmapped: error, reads zero
			end
		end
		// hysteresis comparator
		if (!s_q.ctrl[CTRL_EN]) begin
			s_d.on = 1'b0;
		end else if ({16'h0, dc_link_mv} > s_q.thr) begin
			s_d.on = 1'b1;
		end else if ({16'h0, dc_link_mv} < low) begin
			s_d.on = 1'b0;
		end
		// pin follows the gated comparator, optionally inverted
		s_d.pin = act ^ s_q.ctrl[CTRL_INV];
		// ballast cannot hold the voltage: stop the power stage
		if (s_q.on && s_q.ctrl[CTRL_EN] &&
			{16'h0, dc_link_mv} > s_q.ovv) begin
			if (!s_q.ovv_err) begin
				s_d.code = ERR_OVV;
				s_d.err_pulse = 1'b1;
			end
			s_d.ovv_err = 1'b1;
		end
		// power for the next step from the latest voltage
		if (tick) begin
			s_d.sq = 32'(dc_link_mv) * 32'(dc_link_mv);
			s_d.go = 1'b1;
		end
		if (div_done) s_d.pwr = quo;
		// thermal model, one step per ms
		if (tick) begin
			// net heat: energy in, convection out, floor at zero
			if (s_q.e_th + add > {16'h0, s_q.cool}) begin
				s_d.e_th = s_q.e_th + add - {16'h0, s_q.cool};
			end else begin
				s_d.e_th = 48'h0;
			end
			// surge energy, counted only for its first second
			if (!act) begin
				s_d.e_st = 48'h0;
				s_d.surge = 11'h0;
			end else if (s_q.surge < SURGE_TICKS) begin
				s_d.e_st = s_q.e_st + add;
				s_d.surge = s_q.surge + 11'h1;
			end
			// energy inside the long-term reference window
			if (s_q.win_ms + 32'h1 >= s_q.ltwin) begin
				s_d.e_win = add;
				s_d.win_ms = 32'h0;
			end else begin
				s_d.e_win = s_q.e_win + add;
				s_d.win_ms = s_q.win_ms + 32'h1;
			end
		end
		// block the resistor and warn, release after cooling
		if (over && !s_q.inh) begin
			s_d.inh = 1'b1;
			s_d.warn = 1'b1;
			s_d.code = ERR_ENERGY;
			s_d.err_pulse = 1'b1;
		end else if (s_q.inh && rel) begin
			s_d.inh = 1'b0;
		end
		// parameter check has the last word on the code
		s_d.perr = perr_now;
		if (perr_now && !s_q.perr) begin
			s_d.code = ERR_PARAM;
			s_d.err_pulse = 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_q <= '0;
			s_q.ovv <= RST_OVV;
			// perr starts clear so the zeroed set reports its code once
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from the state register
	assign prdata     = s_q.rdata;
	assign pready     = s_q.ready;
	assign pslverr    = s_q.slverr;
	assign ballast_pin = s_q.pin;
	assign stage_off  = s_q.ovv_err;
	assign err_code   = s_q.code;
	assign err_strobe = s_q.err_pulse;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	chk_pin_disabled: assert property (
		!s_q.ctrl[CTRL_EN] |=> ##1 ballast_pin == $past(s_q.ctrl[CTRL_INV]))
		else $error("pin active while ballast disabled");
	chk_pin_polarity: assert property (
		act |=> ballast_pin == !$past(s_q.ctrl[CTRL_INV]))
		else $error("pin polarity wrong");
	chk_thr_switch_on: assert property (
		s_q.ctrl[CTRL_EN] && {16'h0, dc_link_mv} > s_q.thr |=> s_q.on)
		else $error("ballast not on above threshold");
	chk_hyst_off: assert property (
		s_q.on && {16'h0, dc_link_mv} < low |=> !s_q.on)
		else $error("ballast not off below hysteresis");
	chk_ovv_stage: assert property (
		s_q.on && s_q.ctrl[CTRL_EN] && {16'h0, dc_link_mv} > s_q.ovv
		|=> stage_off ##1 stage_off)
		else $error("stage not shut down on overvoltage");
	chk_cool_drain: assert property (
		tick && !act && s_q.e_th >= {16'h0, s_q.cool}
		|=> s_q.e_th == $past(s_q.e_th) - {16'h0, $past(s_q.cool)})
		else $error("cooling not applied");
	chk_inhibit_warn: assert property (
		over && !s_q.inh && !perr_now
		|=> s_q.inh && s_q.warn && err_code == ERR_ENERGY && err_strobe)
		else $error("energy limit not enforced");
	chk_auto_release: assert property (
		s_q.inh && rel |=> !s_q.inh)
		else $error("inhibit not lifted after cooling");
	chk_param_error: assert property (
		s_q.res == 32'h0 && !s_q.perr |=> s_q.perr && err_code == ERR_PARAM)
		else $error("invalid parameters not flagged");
	chk_apb_ready: assert property (
		psel && penable && !pready |=> pready ##1 !pready)
		else $error("apb answer not one cycle");
endmodule : dcb_ballast

// [tb/dcb_ext_ballast.sv]
// behavioural model of the external ballast driver, switch and resistor
`timescale 1ns/100ps
module dcb_ext_ballast #(
	parameter int          LAG  = 3,       // driver lag, 1..8 cycles
	parameter logic [15:0] DROP = 16'h0032 // sag while resistor conducts
) (
	// clock
	input  wire logic        ref_clk,
	// gate drive from the block, and how the driver is wired
	input  wire logic        ballast_pin,
	input  wire logic        inv,
	// dc-link source and what the block senses
	input  wire logic [15:0] v_src,
	output wire logic [15:0] dc_link_mv,
	output wire logic        res_on
);
	// ----------------------------------------
	// driver stage
	// ----------------------------------------
	logic [7:0] dly_q = 8'h00; // gate delay line, starts switched off

	// a slow driver: the switch follows the gate only after LAG cycles
	always_ff @(posedge ref_clk) begin
		dly_q <= {dly_q[6:0], ballast_pin ^ inv};
	end
	assign res_on = dly_q[LAG-1];

	// conducting resistor pulls the link down a little, never below zero
	assign dc_link_mv = (res_on && v_src > DROP) ? v_src - DROP : v_src;
endmodule : dcb_ext_ballast

// [tb/tb.sv]
// self-checking bench for the dc-link ballast controller
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
	fail_count++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb;
	import dcb_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic        ref_clk, srst;          // clock, reset
	logic        psel, penable, pwrite;  // apb request
	logic [31:0] paddr, pwdata, prdata;  // apb address, data
	logic        pready, pslverr;        // apb answer
	logic [15:0] dc_link_mv, v_src;      // sensed, source voltage
	logic        ballast_pin, stage_off; // block outputs
	logic [15:0] err_code;               // last error code
	logic        err_strobe, res_on;     // strobe, switch state
	logic        inv;                    // driver wired active low
	logic [31:0] rd, wv;                 // read data, random value
	logic        er;                     // slave error, last transfer
	int          fail_count = 0;         // mismatches
	int          check_count = 0;        // comparisons
	int          cyc_n = 0;              // run length guard
	int          strobes = 0;            // error strobes seen
	int          i, s0, n;               // loop helpers
	localparam logic [15:0] THR = 16'h4E20; // 20000 mV
	localparam logic [15:0] HYS = 16'h07D0; // 2000 mV
	localparam logic [15:0] VHI = 16'h61A8; // 25000 mV

	dcb_ballast #(.TICK_CYC_P(100)) u_dcb_ballast (.ref_clk(ref_clk),
		.srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .dc_link_mv(dc_link_mv),
		.ballast_pin(ballast_pin), .stage_off(stage_off),
		.err_code(err_code), .err_strobe(err_strobe));
	dcb_ext_ballast u_dcb_ext_ballast (.ref_clk(ref_clk),
		.ballast_pin(ballast_pin), .inv(inv), .v_src(v_src),
		.dc_link_mv(dc_link_mv), .res_on(res_on));

	// ----------------------------------------
	// clock, guard and strobe count
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// a hang ends the run as a failure
	always @(posedge ref_clk) begin
		cyc_n++;
		if (err_strobe === 1'b1) strobes++;
		if (cyc_n == 60000) begin
			fail_count++;
			report_and_stop();
		end
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk);
	endtask : cyc
	function automatic logic [31:0] ba(input logic [3:0] ix);
		return {26'h0, ix, 2'b00};
	endfunction : ba
	// one apb transfer, held until pready is seen, then an idle cycle;
	// only the bench guard ends a wait that never gets its answer
	task automatic apb(input logic w, input logic [31:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb
	task automatic setv(input logic [15:0] v);
		v_src <= v;
		cyc(6);
	endtask : setv
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : report_and_stop

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		srst = 1'b1;
		{psel, penable, pwrite, inv} = 4'h0;
		{paddr, pwdata} = 64'h0;
		v_src = 16'h0000;
		void'($urandom(32'hC1E0));
		cyc(16);
		srst <= 1'b0;
		cyc(2);
		// zeroed parameters are invalid straight out of reset
		`CHK("code", ERR_PARAM, err_code)
		for (i = 1; i <= 8; i++) begin
			apb(1'b0, ba(4'(i)), 32'h0);
			`CHK("rst", RST_REG, rd)
		end
		apb(1'b0, ba(IDX_OVV), 32'h0);
		`CHK("ovv", RST_OVV, rd)
		apb(1'b0, ba(IDX_STAT), 32'h0);
		`CHK("stat", 5'h02, rd[4:0])
		// unmapped place, then the read-only code register
		apb(1'b0, 32'h0000_0030, 32'h0);
		`CHK("slverr", 1'b1, er)
		apb(1'b1, ba(IDX_CODE), 32'h0000_1234);
		apb(1'b0, ba(IDX_CODE), 32'h0);
		`CHK("code_ro", 32'h0000_7110, rd)
		for (i = 2; i <= 9; i++) begin
			wv = $urandom();
			apb(1'b1, ba(4'(i)), wv);
			apb(1'b0, ba(4'(i)), 32'h0);
			`CHK("rw", wv, rd)
		end
		// sane set: one second window, long cap above the short one,
		// so release waits on cooling and not on the window
		apb(1'b1, ba(IDX_THR), 32'(THR));
		apb(1'b1, ba(IDX_HYST), 32'(HYS));
		apb(1'b1, ba(IDX_RES), 32'h0000_03E8);
		apb(1'b1, ba(IDX_LTCAP), 32'h0000_61A8);
		apb(1'b1, ba(IDX_LTWIN), 32'h0000_03E8);
		apb(1'b1, ba(IDX_STCAP), 32'h0000_4E20);
		apb(1'b1, ba(IDX_COOL), 32'h0002_625A);
		apb(1'b1, ba(IDX_OVV), 32'h0000_7530);
		setv(THR + 16'(100 + $urandom_range(5000)));
		`CHK("pin_dis", 1'b0, ballast_pin)
		apb(1'b1, ba(IDX_CTRL), 32'h1);
		cyc(3);
		`CHK("pin_on", 1'b1, ballast_pin)
		setv(THR - HYS + 16'(100 + $urandom_range(1800)));
		`CHK("pin_hold", 1'b1, ballast_pin)
		setv(THR - HYS - 16'(100 + $urandom_range(1000)));
		`CHK("pin_off", 1'b0, ballast_pin)
		// inverted pin: driver is wired active low
		apb(1'b1, ba(IDX_CTRL), 32'h3);
		inv <= 1'b1;
		cyc(3);
		`CHK("inv_off", 1'b1, ballast_pin)
		setv(VHI);
		`CHK("inv_on", 1'b0, ballast_pin)
		`CHK("res_on", 1'b1, res_on)
		apb(1'b1, ba(IDX_CTRL), 32'h1);
		inv <= 1'b0;
		setv(16'h7918);
		`CHK("stage", 1'b1, stage_off)
		`CHK("ovcode", ERR_OVV, err_code)
		setv(16'h0000);
		apb(1'b1, ba(IDX_STAT), 32'h4);
		cyc(2);
		`CHK("stage_clr", 1'b0, stage_off)
		// sustained load until the energy model blocks the resistor
		s0 = strobes;
		v_src <= VHI;
		n = 0;
		while (err_code !== ERR_ENERGY && n < 20000) begin
			cyc(1);
			n++;
		end
		cyc(3);
		`CHK("ecode", ERR_ENERGY, err_code)
		`CHK("e_strobe", s0 + 1, strobes)
		`CHK("pin_inh", 1'b0, ballast_pin)
		apb(1'b0, ba(IDX_STAT), 32'h0);
		`CHK("inh", 2'b11, {rd[ST_WARN], rd[ST_INH]})
		setv(16'h0000);
		n = 0;
		do begin
			apb(1'b0, ba(IDX_STAT), 32'h0);
			n++;
		end while (rd[ST_INH] !== 1'b0 && n < 3000);
		`CHK("release", 1'b0, rd[ST_INH])
		setv(VHI);
		`CHK("pin_back", 1'b1, ballast_pin)
		s0 = strobes;
		apb(1'b1, ba(IDX_RES), 32'h0);
		cyc(4);
		`CHK("p_code", ERR_PARAM, err_code)
		`CHK("p_strobe", s0 + 1, strobes)
		`CHK("p_pin", 1'b0, ballast_pin)
		report_and_stop();
	end
endmodule : tb
